// [hdl/ist_pkg.sv]
// Constants and types shared by the drive strobe timing block
package ist_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int IDX_W  = 4;
  localparam int MEM_DEPTH = 16;
  localparam int CNT_W  = 5;
  localparam int NUM_CH = 2;

  // Register offsets, primary and secondary channel
  localparam logic [ADDR_W-1:0] OFS_RD_PRI   = 9'h1F0;
  localparam logic [ADDR_W-1:0] OFS_WR_PRI   = 9'h1F1;
  localparam logic [ADDR_W-1:0] OFS_MISC_PRI = 9'h1F6;
  localparam logic [ADDR_W-1:0] OFS_RD_SEC   = 9'h170;
  localparam logic [ADDR_W-1:0] OFS_WR_SEC   = 9'h171;
  localparam logic [ADDR_W-1:0] OFS_MISC_SEC = 9'h176;

  // Field positions
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 4;
  localparam int REC_MSB = 3;
  localparam int REC_LSB = 0;
  localparam int RDY_MSB = 3;
  localparam int RDY_LSB = 1;
  localparam int SET_BIT = 0;

  // Code to clock count offsets
  localparam logic [CNT_W-1:0] REC_BIAS = 5'h01;
  localparam logic [CNT_W-1:0] RDY_BIAS = 5'h02;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 5'h1F;

  // Storage layout: timing entry {0,chan,set,write}, misc entry {1,0,0,chan}
  localparam logic [IDX_W-1:0] MISC_IDX_BASE = 4'h8;

  localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [NUM_CH-1:0] STROBE_IDLE = 2'h3;

  typedef enum logic [1:0] {
    IST_IDLE,
    IST_LOAD,
    IST_STROBE,
    IST_RECOVER
  } ist_state_t;
endpackage : ist_pkg

// [hdl/ist_regmem.sv]
// Register storage with one write port and two registered read ports
`timescale 1ns/1ps
module ist_regmem (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [ist_pkg::IDX_W-1:0]     wr_idx,
  input  wire logic [ist_pkg::DATA_W-1:0]    wr_data,
  // Software read port
  input  wire logic                          rd_en_a,
  input  wire logic [ist_pkg::IDX_W-1:0]     rd_idx_a,
  output logic      [ist_pkg::DATA_W-1:0]    rd_data_a,
  // Cycle engine read port
  input  wire logic [ist_pkg::IDX_W-1:0]     rd_idx_b,
  output logic      [ist_pkg::DATA_W-1:0]    rd_data_b
);
  logic [ist_pkg::DATA_W-1:0] mem_ff [ist_pkg::MEM_DEPTH];
  logic [ist_pkg::DATA_W-1:0] nxt_rd_a;
  logic [ist_pkg::DATA_W-1:0] nxt_rd_b;

  // Unmapped or idle reads on the software port return zero so the data lane is clean
  always_comb begin
    nxt_rd_a = rd_en_a ? mem_ff[rd_idx_a] : ist_pkg::DATA_ZERO;
    nxt_rd_b = mem_ff[rd_idx_b];
  end

  for (genvar i = 0; i < ist_pkg::MEM_DEPTH; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (srst) begin
        mem_ff[i] <= ist_pkg::REG_RST;
      end else if (wr_en && wr_idx == (ist_pkg::IDX_W)'(i)) begin
        mem_ff[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_a <= ist_pkg::DATA_ZERO;
      rd_data_b <= ist_pkg::DATA_ZERO;
    end else begin
      rd_data_a <= nxt_rd_a;
      rd_data_b <= nxt_rd_b;
    end
  end
endmodule : ist_regmem

// [hdl/ist_strobe_timing.sv]
// Programmable drive read/write strobe timing for two IDE channels
`timescale 1ns/1ps
module ist_strobe_timing (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Register port
  input  wire logic [ist_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ist_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ist_pkg::DATA_W-1:0]    reg_rdata,
  // Cycle request
  input  wire logic                          cyc_req,
  input  wire logic                          cyc_write,
  input  wire logic                          cyc_chan,
  input  wire logic                          cyc_set,
  output logic                               cyc_busy_ff,
  output logic                               cyc_done_ff,
  // Drive pins, one per channel
  input  wire logic [ist_pkg::NUM_CH-1:0]    drive_ready_n,
  output logic      [ist_pkg::NUM_CH-1:0]    drive_read_strobe_n_ff,
  output logic      [ist_pkg::NUM_CH-1:0]    drive_write_strobe_n_ff
);
  // Returns {valid, storage index}; timing entries follow the channel's set bit
  function automatic logic [ist_pkg::IDX_W:0] ist_decode(
    input logic [ist_pkg::ADDR_W-1:0] addr,
    input logic [ist_pkg::NUM_CH-1:0] set_sel
  );
    logic [ist_pkg::IDX_W:0] res;
    res = '0;
    case (addr)
      ist_pkg::OFS_RD_PRI:   res = {1'b1, 1'b0, 1'b0, set_sel[0], 1'b0};
      ist_pkg::OFS_WR_PRI:   res = {1'b1, 1'b0, 1'b0, set_sel[0], 1'b1};
      ist_pkg::OFS_RD_SEC:   res = {1'b1, 1'b0, 1'b1, set_sel[1], 1'b0};
      ist_pkg::OFS_WR_SEC:   res = {1'b1, 1'b0, 1'b1, set_sel[1], 1'b1};
      ist_pkg::OFS_MISC_PRI: res = {1'b1, ist_pkg::MISC_IDX_BASE};
      ist_pkg::OFS_MISC_SEC: res = {1'b1, ist_pkg::MISC_IDX_BASE | 4'h1};
      default:               res = '0;
    endcase
    return res;
  endfunction : ist_decode

  logic [ist_pkg::DATA_W-1:0] misc_ff [ist_pkg::NUM_CH];
  logic [ist_pkg::DATA_W-1:0] nxt_misc [ist_pkg::NUM_CH];
  logic [ist_pkg::NUM_CH-1:0] set_sel;
  logic [ist_pkg::IDX_W:0]    wr_dec;
  logic [ist_pkg::IDX_W:0]    rd_dec;
  logic [ist_pkg::IDX_W-1:0]  eng_idx;
  logic [ist_pkg::DATA_W-1:0] eng_data;

  ist_pkg::ist_state_t        state_ff;
  ist_pkg::ist_state_t        nxt_state;
  logic                       chan_ff;
  logic                       nxt_chan;
  logic                       write_ff;
  logic                       nxt_write;
  logic [ist_pkg::CNT_W-1:0]  cnt_ff;
  logic [ist_pkg::CNT_W-1:0]  nxt_cnt;
  logic [ist_pkg::CNT_W-1:0]  rec_ff;
  logic [ist_pkg::CNT_W-1:0]  nxt_rec;
  logic [ist_pkg::CNT_W-1:0]  dly_ff;
  logic [ist_pkg::CNT_W-1:0]  nxt_dly;
  logic [ist_pkg::CNT_W-1:0]  rdy_cnt_ff;
  logic [ist_pkg::CNT_W-1:0]  nxt_rdy_cnt;
  logic                       nxt_busy;
  logic                       nxt_done;
  logic [ist_pkg::NUM_CH-1:0] nxt_rd_n;
  logic [ist_pkg::NUM_CH-1:0] nxt_wr_n;
  logic                       ready_n_sel;
  logic                       ready_ok;

  // Register access decode
  always_comb begin
    for (int c = 0; c < ist_pkg::NUM_CH; c++) begin
      set_sel[c] = misc_ff[c][ist_pkg::SET_BIT];
    end
    wr_dec = ist_decode(reg_addr, set_sel);
    rd_dec = ist_decode(reg_addr, set_sel);
  end

  // Engine reads the entry of the requested channel, set and direction
  assign eng_idx = {1'b0, cyc_chan, cyc_set, cyc_write};

  // Every channel, set and direction has its own storage word
  ist_regmem u_regmem (
    .clk       (clk),
    .srst      (srst),
    .wr_en     (reg_wr & wr_dec[ist_pkg::IDX_W]),
    .wr_idx    (wr_dec[ist_pkg::IDX_W-1:0]),
    .wr_data   (reg_wdata),
    .rd_en_a   (reg_rd & rd_dec[ist_pkg::IDX_W]),
    .rd_idx_a  (rd_dec[ist_pkg::IDX_W-1:0]),
    .rd_data_a (reg_rdata),
    .rd_idx_b  (eng_idx),
    .rd_data_b (eng_data)
  );

  // Misc registers are mirrored here because they steer decode and timing
  always_comb begin
    for (int c = 0; c < ist_pkg::NUM_CH; c++) begin
      nxt_misc[c] = misc_ff[c];
      if (reg_wr && wr_dec == {1'b1, ist_pkg::MISC_IDX_BASE | 4'(c)}) begin
        nxt_misc[c] = reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int c = 0; c < ist_pkg::NUM_CH; c++) begin
      misc_ff[c] <= srst ? ist_pkg::REG_RST : nxt_misc[c];
    end
  end

  assign ready_n_sel = drive_ready_n[chan_ff];
  assign ready_ok    = ready_n_sel && rdy_cnt_ff == ist_pkg::CNT_ZERO;

  // Cycle engine
  always_comb begin
    nxt_state   = state_ff;
    nxt_chan    = chan_ff;
    nxt_write   = write_ff;
    nxt_cnt     = cnt_ff;
    nxt_rec     = rec_ff;
    nxt_dly     = dly_ff;
    nxt_busy    = cyc_busy_ff;
    nxt_done    = 1'b0;
    // Ready low restarts the delay; it only counts down while ready is high
    if (!ready_n_sel) begin
      nxt_rdy_cnt = dly_ff;
    end else if (rdy_cnt_ff != ist_pkg::CNT_ZERO) begin
      nxt_rdy_cnt = rdy_cnt_ff - ist_pkg::CNT_ONE;
    end else begin
      nxt_rdy_cnt = rdy_cnt_ff;
    end
    case (state_ff)
      ist_pkg::IST_IDLE: begin
        if (cyc_req) begin
          nxt_state = ist_pkg::IST_LOAD;
          nxt_chan  = cyc_chan;
          nxt_write = cyc_write;
          nxt_busy  = 1'b1;
        end
      end
      ist_pkg::IST_LOAD: begin
        // Strobe width at least n+1: low while counting n down to zero, longer if the ready wait runs past it
        nxt_cnt = {1'b0, eng_data[ist_pkg::CMD_MSB:ist_pkg::CMD_LSB]};
        nxt_rec = {1'b0, eng_data[ist_pkg::REC_MSB:ist_pkg::REC_LSB]}
                  + ist_pkg::REC_BIAS;
        nxt_dly = {2'b00, misc_ff[chan_ff][ist_pkg::RDY_MSB:ist_pkg::RDY_LSB]}
                  + ist_pkg::RDY_BIAS;
        nxt_rdy_cnt = nxt_dly;
        nxt_state   = ist_pkg::IST_STROBE;
      end
      ist_pkg::IST_STROBE: begin
        if (cnt_ff != ist_pkg::CNT_ZERO) begin
          nxt_cnt = cnt_ff - ist_pkg::CNT_ONE;
        end else if (ready_ok) begin
          // Recovery starts only after the strobe and the ready wait are done
          nxt_cnt   = rec_ff;
          nxt_state = ist_pkg::IST_RECOVER;
        end
      end
      ist_pkg::IST_RECOVER: begin
        if (cnt_ff != ist_pkg::CNT_ZERO) begin
          nxt_cnt = cnt_ff - ist_pkg::CNT_ONE;
        end else begin
          nxt_state = ist_pkg::IST_IDLE;
          nxt_busy  = 1'b0;
          nxt_done  = 1'b1;
        end
      end
      default: begin
        nxt_state = ist_pkg::IST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // Strobes follow the next state so the pins and the state change together
  for (genvar c = 0; c < ist_pkg::NUM_CH; c++) begin : g_pin
    always_comb begin
      nxt_rd_n[c] = !(nxt_state == ist_pkg::IST_STROBE && !nxt_write && nxt_chan == c);
      nxt_wr_n[c] = !(nxt_state == ist_pkg::IST_STROBE && nxt_write && nxt_chan == c);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff                <= ist_pkg::IST_IDLE;
      chan_ff                 <= 1'b0;
      write_ff                <= 1'b0;
      cnt_ff                  <= ist_pkg::CNT_ZERO;
      rec_ff                  <= ist_pkg::CNT_ZERO;
      dly_ff                  <= ist_pkg::RDY_BIAS;
      rdy_cnt_ff              <= ist_pkg::CNT_ZERO;
      cyc_busy_ff             <= 1'b0;
      cyc_done_ff             <= 1'b0;
      drive_read_strobe_n_ff  <= ist_pkg::STROBE_IDLE;
      drive_write_strobe_n_ff <= ist_pkg::STROBE_IDLE;
    end else begin
      state_ff                <= nxt_state;
      chan_ff                 <= nxt_chan;
      write_ff                <= nxt_write;
      cnt_ff                  <= nxt_cnt;
      rec_ff                  <= nxt_rec;
      dly_ff                  <= nxt_dly;
      rdy_cnt_ff              <= nxt_rdy_cnt;
      cyc_busy_ff             <= nxt_busy;
      cyc_done_ff             <= nxt_done;
      drive_read_strobe_n_ff  <= nxt_rd_n;
      drive_write_strobe_n_ff <= nxt_wr_n;
    end
  end

  // Checking helpers: cycles spent in the current state, cycles ready high
  logic [ist_pkg::CNT_W-1:0] len_ff;
  logic [ist_pkg::CNT_W-1:0] hi_len_ff;
  logic [3:0]                cmd_code_ff;
  logic [3:0]                rec_code_ff;

  always_ff @(posedge clk) begin
    if (srst || nxt_state != state_ff) begin
      len_ff <= ist_pkg::CNT_ZERO;
    end else if (len_ff != ist_pkg::CNT_MAX) begin
      len_ff <= len_ff + ist_pkg::CNT_ONE;
    end
    if (srst || !ready_n_sel) begin
      hi_len_ff <= ist_pkg::CNT_ZERO;
    end else if (hi_len_ff != ist_pkg::CNT_MAX) begin
      hi_len_ff <= hi_len_ff + ist_pkg::CNT_ONE;
    end
    if (state_ff == ist_pkg::IST_LOAD) begin
      cmd_code_ff <= eng_data[ist_pkg::CMD_MSB:ist_pkg::CMD_LSB];
      rec_code_ff <= eng_data[ist_pkg::REC_MSB:ist_pkg::REC_LSB];
    end
  end

  ready_delay_code_a: assert property (
    @(posedge clk) disable iff (srst)
    state_ff == ist_pkg::IST_LOAD |=>
      dly_ff == 5'({2'b00, $past(misc_ff[chan_ff][3:1])} + 5'h02))
    else $error("ready delay is not code plus two");

  ready_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    (state_ff == ist_pkg::IST_STROBE && nxt_state == ist_pkg::IST_RECOVER) |->
      (hi_len_ff >= dly_ff && ready_n_sel))
    else $error("strobe ended too soon after drive ready");

  read_width_a: assert property (
    @(posedge clk) disable iff (srst)
    ($rose(drive_read_strobe_n_ff[chan_ff]) && !write_ff) |->
      $past(len_ff) >= {1'b0, cmd_code_ff})
    else $error("read strobe shorter than programmed");

  write_width_a: assert property (
    @(posedge clk) disable iff (srst)
    ($rose(drive_write_strobe_n_ff[chan_ff]) && write_ff) |->
      $past(len_ff) >= {1'b0, cmd_code_ff})
    else $error("write strobe shorter than programmed");

  read_recovery_a: assert property (
    @(posedge clk) disable iff (srst)
    (state_ff == ist_pkg::IST_RECOVER && nxt_state == ist_pkg::IST_IDLE && !write_ff) |->
      len_ff == 5'({1'b0, rec_code_ff} + 5'h01) ##1 cyc_done_ff)
    else $error("read recovery length wrong");

  write_recovery_a: assert property (
    @(posedge clk) disable iff (srst)
    (state_ff == ist_pkg::IST_RECOVER && nxt_state == ist_pkg::IST_IDLE && write_ff) |->
      len_ff == 5'({1'b0, rec_code_ff} + 5'h01) ##1 cyc_done_ff)
    else $error("write recovery length wrong");

  channel_isolation_a: assert property (
    @(posedge clk) disable iff (srst)
    cyc_busy_ff |-> (drive_read_strobe_n_ff[!chan_ff] && drive_write_strobe_n_ff[!chan_ff]))
    else $error("idle channel strobe moved");

  set_select_a: assert property (
    @(posedge clk) disable iff (srst)
    (reg_wr && wr_dec[ist_pkg::IDX_W] && !wr_dec[3]) |->
      wr_dec[1] == misc_ff[wr_dec[2]][0])
    else $error("timing write reached the wrong set");

  phase_order_a: assert property (
    @(posedge clk) disable iff (srst)
    (!(&drive_read_strobe_n_ff) || !(&drive_write_strobe_n_ff)) |->
      state_ff == ist_pkg::IST_STROBE && cyc_busy_ff && !cyc_done_ff)
    else $error("strobe active outside its phase");
endmodule : ist_strobe_timing

// [bench/ist_drive_model.sv]
// Drive side model: holds ready low a set number of clocks after each strobe falls
`timescale 1ns/1ps
module ist_drive_model (
  // Clock
  input  wire logic                          clk,
  // Strobes from the controller, one per channel
  input  wire logic [ist_pkg::NUM_CH-1:0]    rd_strobe_n,
  input  wire logic [ist_pkg::NUM_CH-1:0]    wr_strobe_n,
  // Ready hold length in clocks, 0 means ready throughout
  input  wire logic [7:0]                    hold_clks,
  // Ready sense, high means ready
  output logic      [ist_pkg::NUM_CH-1:0]    drive_ready_n
);
  logic [ist_pkg::NUM_CH-1:0][7:0] low_cnt_ff;

  initial low_cnt_ff = '0;

  // Cable has a pull-up on ready, so an idle drive reads as ready
  always @(posedge clk) begin
    for (int c = 0; c < ist_pkg::NUM_CH; c++) begin
      if (rd_strobe_n[c] & wr_strobe_n[c]) low_cnt_ff[c] <= 8'h00;
      else if (low_cnt_ff[c] != 8'hFF) low_cnt_ff[c] <= low_cnt_ff[c] + 8'h01;
    end
  end

  always_comb begin
    for (int c = 0; c < ist_pkg::NUM_CH; c++) begin
      drive_ready_n[c] = (rd_strobe_n[c] & wr_strobe_n[c]) | (low_cnt_ff[c] >= hold_clks);
    end
  end
endmodule : ist_drive_model

// [bench/ist_strobe_timing_tb.sv]
// Self-checking testbench for the drive strobe timing block
`timescale 1ns/1ps
module ist_strobe_timing_tb;
  logic                          clk, srst, reg_wr, reg_rd, cyc_req, cyc_write, cyc_chan, cyc_set;
  logic [ist_pkg::ADDR_W-1:0]    reg_addr;
  logic [ist_pkg::DATA_W-1:0]    reg_wdata, reg_rdata, d;
  logic                          cyc_busy_ff, cyc_done_ff;
  logic [ist_pkg::NUM_CH-1:0]    drive_ready_n, rd_n, wr_n;
  logic [7:0]                    hold_clks, w, r, aft;
  logic                          bad;
  int                            failures, num_checks;
  // Entries {chan, set, write, timing word}
  localparam logic [10:0] TBL [8] = '{11'h030, 11'h1F5, 11'h27F, 11'h341,
                                      11'h452, 11'h59A, 11'h6A0, 11'h73E};

  ist_strobe_timing uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_req(cyc_req),
    .cyc_write(cyc_write), .cyc_chan(cyc_chan), .cyc_set(cyc_set), .cyc_busy_ff(cyc_busy_ff),
    .cyc_done_ff(cyc_done_ff), .drive_ready_n(drive_ready_n), .drive_read_strobe_n_ff(rd_n),
    .drive_write_strobe_n_ff(wr_n));
  ist_drive_model u_drive (.clk(clk), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
    .hold_clks(hold_clks), .drive_ready_n(drive_ready_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // at_least turns the compare into a lower bound
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input bit at_least);
    num_checks++;
    if (at_least ? !((^got !== 1'bx) && got >= exp) : (got !== exp)) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [8:0] tim_addr(input logic ch, input logic wr);
    if (ch) return wr ? ist_pkg::OFS_WR_SEC : ist_pkg::OFS_RD_SEC;
    return wr ? ist_pkg::OFS_WR_PRI : ist_pkg::OFS_RD_PRI;
  endfunction : tim_addr

  function automatic logic [8:0] misc_addr(input logic ch);
    return ch ? ist_pkg::OFS_MISC_SEC : ist_pkg::OFS_MISC_PRI;
  endfunction : misc_addr

  // Idle cycle after the strobe keeps two writes from touching reg_wr in one step
  task automatic reg_write(input logic [8:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task automatic reg_check(input logic [8:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp, 1'b0);
    @(posedge clk);
  endtask : reg_check

  // Counts strobe low samples, recovery samples and low samples after ready was seen
  task automatic run_cycle(input logic wr, input logic ch, input logic set, input logic [7:0] hold);
    logic rdy_seen, done_seen, strb;
    rdy_seen = 1'b0;
    done_seen = 1'b0;
    w = 8'h00;
    r = 8'h00;
    aft = 8'h00;
    bad = 1'b0;
    hold_clks <= hold;
    cyc_req <= 1'b1;
    cyc_write <= wr;
    cyc_chan <= ch;
    cyc_set <= set;
    @(posedge clk);
    cyc_req <= 1'b0;
    for (int n = 0; n < 300 && !done_seen; n++) begin
      @(negedge clk);
      strb = wr ? wr_n[ch] : rd_n[ch];
      if ((wr ? rd_n : wr_n) !== 2'h3 || (wr ? wr_n[!ch] : rd_n[!ch]) !== 1'b1) bad = 1'b1;
      if (cyc_done_ff === 1'b1) done_seen = 1'b1;
      else if (strb === 1'b0) begin
        w++;
        if (rdy_seen) aft++;
        if (cyc_busy_ff !== 1'b1) bad = 1'b1;
      end else if (w != 8'h00) r++;
      if (strb === 1'b0 && drive_ready_n[ch] === 1'b1) rdy_seen = 1'b1;
    end
    if (!done_seen) bad = 1'b1;
    @(posedge clk);
  endtask : run_cycle

  initial begin
    #500000;
    failures++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    srst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cyc_req = 1'b0;
    cyc_write = 1'b0;
    cyc_chan = 1'b0;
    cyc_set = 1'b0;
    hold_clks = 8'h00;
    failures = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) reg_check(tim_addr(i[1], i[0]), 8'h00);
    reg_check(misc_addr(1'b0), 8'h00);
    reg_check(9'h1F2, 8'h00);
    $display("test reset values done");

    for (int i = 0; i < 8; i++) begin
      reg_write(misc_addr(TBL[i][10]), {7'h00, TBL[i][9]});
      reg_write(tim_addr(TBL[i][10], TBL[i][8]), TBL[i][7:0]);
    end
    reg_write(9'h1F2, 8'hA5);
    reg_check(9'h1F2, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_write(misc_addr(TBL[i][10]), {7'h00, TBL[i][9]});
      reg_check(misc_addr(TBL[i][10]), {7'h00, TBL[i][9]});
      reg_check(tim_addr(TBL[i][10], TBL[i][8]), TBL[i][7:0]);
    end
    $display("test register sets done");

    // Every strobe width is at least 4 so the default ready delay of 2 never widens it
    for (int i = 0; i < 8; i++) begin
      run_cycle(TBL[i][8], TBL[i][10], TBL[i][9], 8'h00);
      check(w, {4'h0, TBL[i][7:4]} + 8'h01, 1'b0);
      check(r, {4'h0, TBL[i][3:0]} + 8'h02, 1'b0);
      check({7'h00, bad}, 8'h00, 1'b0);
    end
    $display("test strobe and recovery done");

    for (int n = 0; n < 8; n++) begin
      reg_write(misc_addr(1'b1), {4'h0, n[2:0], 1'b0});
      run_cycle(1'b0, 1'b1, 1'b0, 8'h05);
      check(aft, n[7:0] + 8'h02, 1'b1);
      check(w, 8'h06, 1'b1);
      check(r, 8'h04, 1'b0);
      check({7'h00, bad}, 8'h00, 1'b0);
    end
    $display("test ready delay done");
    final_report();
  end
endmodule : ist_strobe_timing_tb
